// >>> hw/sxu_cfg.svh
`ifndef SXU_CFG_SVH
`define SXU_CFG_SVH

// Datapath widths
`define SXU_XLEN 32
`define SXU_CODE_W 5
`define SXU_COPN_W 2

// Cause codes, one distinct value per exception type
`define SXU_CODE_NONE 5'h00
`define SXU_CODE_IBE 5'h06
`define SXU_CODE_DBE 5'h07
`define SXU_CODE_SYS 5'h08
`define SXU_CODE_BP 5'h09
`define SXU_CODE_RI 5'h0a
`define SXU_CODE_CPU 5'h0b

// Normal instruction fields
`define SXU_OP_MSB 31
`define SXU_OP_LSB 26
`define SXU_FN_MSB 5
`define SXU_FN_LSB 0
`define SXU_RT_MSB 20
`define SXU_RT_LSB 16
`define SXU_COPN_MSB 27
`define SXU_COPN_LSB 26
`define SXU_COPHI_MSB 31
`define SXU_COPHI_LSB 28
`define SXU_OP_SPECIAL 6'h00
`define SXU_OP_REG_IMMEDIATE_GROUP 6'h01
`define SXU_OP_COP_HI 4'h4
`define SXU_FN_SYSTEM_CALL_INSTRUCTION 6'h0c
`define SXU_FN_BREAK 6'h0d

// Defined-opcode and 64-bit-opcode tables, one bit per code
`define SXU_MAJOR_DEF 64'hbcff_bcff_cf00_ffff
`define SXU_MAJOR_WIDE 64'h8090_8080_0f00_0000
`define SXU_SPECIAL_DEF 64'hdddd_f3ff_ffff_33d5
`define SXU_SPECIAL_WIDE 64'hddd0_f000_00f0_0094
`define SXU_REG_IMMEDIATE_GROUP_DEF 32'h000f_5f0f

// Compact instruction fields and tables
`define SXU_C_OP_MSB 15
`define SXU_C_OP_LSB 11
`define SXU_C_RR_MSB 4
`define SXU_C_RR_LSB 0
`define SXU_C_I8_MSB 10
`define SXU_C_I8_LSB 8
`define SXU_C_OP_RR 5'h1d
`define SXU_C_OP_I8 5'h0c
`define SXU_C_RR_BREAK 5'h05
`define SXU_C_RR_DEF 32'hfffb_1fa1
`define SXU_C_I8_DEF 8'h7f

// Reset value of the restart address
`define SXU_ADDR_RST 32'h0000_0000

`endif

// >>> hw/sxu_pkg.sv
`include "sxu_cfg.svh"

package sxu_pkg;

  // Control states
  typedef enum logic [1:0] {
    SXU_ST_IDLE = 2'b01,
    SXU_ST_FLUSH = 2'b10
  } sxu_state_t;

  // Instruction in the stage where exceptions are taken
  typedef struct packed {
    logic valid;
    logic [`SXU_XLEN-1:0] word;
    logic [`SXU_XLEN-1:0] pc;
    logic [`SXU_XLEN-1:0] prev_pc;
    logic in_delay_slot;
    logic after_extend;
    logic isa_compact;
  } sxu_issue_t;

  // Outstanding memory access that may end in a bus error
  typedef struct packed {
    logic active;
    logic is_fetch;
    logic [`SXU_XLEN-1:0] pc;
    logic [`SXU_XLEN-1:0] prev_pc;
    logic in_delay_slot;
    logic after_extend;
    logic isa_compact;
  } sxu_access_t;

  // Processor mode seen by the checks
  typedef struct packed {
    logic kernel;
    logic wide_user;
    logic [3:0] cop_usable;
    logic compact_en;
    logic streaming;
  } sxu_mode_t;

  // What gets written when an exception is taken
  typedef struct packed {
    logic [`SXU_CODE_W-1:0] code;
    logic [`SXU_COPN_W-1:0] coproc;
    logic [`SXU_XLEN-1:0] restart;
    logic delay_slot;
  } sxu_record_t;

endpackage : sxu_pkg

// >>> hw/sxu_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module sxu_sync2 (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_r;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : sxu_sync2

`default_nettype wire

// >>> hw/sxu_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "sxu_cfg.svh"

module sxu_decode (
  input wire logic [`SXU_XLEN-1:0] word_i,
  input wire logic compact_i,
  input wire sxu_pkg::sxu_mode_t mode_i,
  output logic system_call_instruction_o,
  output logic break_o,
  output logic reserved_o,
  output logic cop_unusable_o,
  output logic [`SXU_COPN_W-1:0] cop_num_o
);

  logic [5:0] op;
  logic [5:0] fn;
  logic [4:0] rt;
  logic [4:0] c_op;
  logic [4:0] c_rr;
  logic [2:0] c_i8;
  logic is_cop;
  logic wide_ok;
  logic [63:0] major_def;
  logic [63:0] major_wide;
  logic [63:0] special_def;
  logic [63:0] special_wide;
  logic [31:0] reg_immediate_group_def;
  logic [31:0] c_rr_def;
  logic [7:0] c_i8_def;

  // Opcode, function and rt fields are looked at; in the special group code bits 25..6 are free
  assign op = word_i[`SXU_OP_MSB:`SXU_OP_LSB];
  assign fn = word_i[`SXU_FN_MSB:`SXU_FN_LSB];
  assign rt = word_i[`SXU_RT_MSB:`SXU_RT_LSB];
  assign c_op = word_i[`SXU_C_OP_MSB:`SXU_C_OP_LSB];
  assign c_rr = word_i[`SXU_C_RR_MSB:`SXU_C_RR_LSB];
  assign c_i8 = word_i[`SXU_C_I8_MSB:`SXU_C_I8_LSB];
  assign major_def = `SXU_MAJOR_DEF;
  assign major_wide = `SXU_MAJOR_WIDE;
  assign special_def = `SXU_SPECIAL_DEF;
  assign special_wide = `SXU_SPECIAL_WIDE;
  assign reg_immediate_group_def = `SXU_REG_IMMEDIATE_GROUP_DEF;
  assign c_rr_def = `SXU_C_RR_DEF;
  assign c_i8_def = `SXU_C_I8_DEF;

  // Kernel always runs 64-bit operations, whatever the wide-address bit says
  assign wide_ok = mode_i.kernel | mode_i.wide_user;

  assign is_cop = !compact_i && (word_i[`SXU_COPHI_MSB:`SXU_COPHI_LSB] == `SXU_OP_COP_HI);
  assign cop_num_o = word_i[`SXU_COPN_MSB:`SXU_COPN_LSB];

  // Kernel mode bypasses only the system-coprocessor usable check
  assign cop_unusable_o = is_cop && !mode_i.cop_usable[cop_num_o] &&
                          !(cop_num_o == 2'h0 && mode_i.kernel);

  assign system_call_instruction_o = !compact_i && op == `SXU_OP_SPECIAL && fn == `SXU_FN_SYSTEM_CALL_INSTRUCTION;
  assign break_o = compact_i ? (c_op == `SXU_C_OP_RR && c_rr == `SXU_C_RR_BREAK) :
                   (op == `SXU_OP_SPECIAL && fn == `SXU_FN_BREAK);

  // Undefined opcodes per group, plus 64-bit ones when not allowed
  always_comb begin
    reserved_o = 1'b0;
    if (compact_i) begin
      if (c_op == `SXU_C_OP_RR) reserved_o = !c_rr_def[c_rr];
      if (c_op == `SXU_C_OP_I8) reserved_o = !c_i8_def[c_i8];
    end else if (op == `SXU_OP_SPECIAL) begin
      reserved_o = !special_def[fn] || (special_wide[fn] && !wide_ok);
    end else if (op == `SXU_OP_REG_IMMEDIATE_GROUP) begin
      reserved_o = !reg_immediate_group_def[rt];
    end else begin
      reserved_o = !major_def[op] || (major_wide[op] && !wide_ok);
    end
  end

endmodule : sxu_decode

`default_nettype wire

// >>> hw/sxu_top.sv
`timescale 1ns/100ps
`default_nettype none

// Field positions, codes and reset values
`include "sxu_cfg.svh"

module sxu_top (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire sxu_pkg::sxu_issue_t issue_i,
  input wire sxu_pkg::sxu_access_t access_i,
  input wire sxu_pkg::sxu_mode_t mode_i,
  input wire logic bus_error_i,
  output logic exc_take_o,
  output logic common_vector_o,
  output logic flush_o,
  output logic [`SXU_CODE_W-1:0] cause_code_field_o,
  output logic [`SXU_COPN_W-1:0] coproc_num_o,
  output logic [`SXU_XLEN-1:0] restart_address_o,
  output logic delay_slot_flag_o
);

  // Control state and its next value
  sxu_pkg::sxu_state_t state_r;
  sxu_pkg::sxu_state_t state_nxt;

  // Chosen record and the candidates it is picked from
  sxu_pkg::sxu_record_t rec_nxt;
  sxu_pkg::sxu_record_t issue_rec;
  sxu_pkg::sxu_record_t access_rec;
  sxu_pkg::sxu_record_t stream_rec;

  // Take decision and the cleaned bus error pin
  logic take_nxt;
  logic bus_error_s;
  logic bus_error_hit;

  // Decoder results for the issuing instruction
  logic dec_system_call_instruction;
  logic dec_break;
  logic dec_reserved;
  logic dec_cop_unusable;
  logic [`SXU_COPN_W-1:0] dec_cop_num;
  logic issue_live;

  // One qualified request per exception source
  logic take_bus;
  logic take_cop;
  logic take_ri;
  logic take_sys;
  logic take_bp;

  // Restart address and slot flag for one instruction.
  // Extend followers only count as slot entries while compact mode is on.
  function automatic sxu_pkg::sxu_record_t sxu_restart(
    input logic [`SXU_XLEN-1:0] pc,
    input logic [`SXU_XLEN-1:0] prev_pc,
    input logic in_slot,
    input logic after_ext,
    input logic isa_compact,
    input logic compact_en
  );
    sxu_pkg::sxu_record_t r;
    logic use_prev;
    r = '0;
    use_prev = in_slot | (compact_en & after_ext);
    r.delay_slot = use_prev;
    r.restart = use_prev ? prev_pc : pc;
    if (compact_en) begin
      r.restart[0] = isa_compact;
    end
    return r;
  endfunction : sxu_restart

  // Pin from board logic is asynchronous to the core; clean it first.
  // The two flops cost two cycles of latency, so the access must still be
  // outstanding when the cleaned level arrives.
  // A strobe shorter than one clock period can be missed, so board logic
  // is expected to hold it for at least a full cycle.
  sxu_sync2 u_berr_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(bus_error_i),
    .sync_o(bus_error_s)
  );

  // Instruction checks for the issuing instruction
  sxu_decode u_decode (
    .word_i(issue_i.word),
    .compact_i(issue_i.isa_compact & mode_i.compact_en),
    .mode_i(mode_i),
    .system_call_instruction_o(dec_system_call_instruction),
    .break_o(dec_break),
    .reserved_o(dec_reserved),
    .cop_unusable_o(dec_cop_unusable),
    .cop_num_o(dec_cop_num)
  );

  // A bus error only counts while a qualifying access is still outstanding;
  // stray pulses between accesses are dropped on purpose.
  // No mask or enable input exists anywhere in this path.
  assign bus_error_hit = bus_error_s & access_i.active;

  // The pipeline is being flushed during the flush state, so the
  // instruction then presented is a dead one and must not trap.
  assign issue_live = issue_i.valid & (state_r == sxu_pkg::SXU_ST_IDLE);

  // Qualified requests, one per source. The flush cycle refuses them all,
  // so a take is never followed at once by a second one that would
  // overwrite the record before the handler has seen it.
  assign take_bus = (state_r == sxu_pkg::SXU_ST_IDLE) & bus_error_hit;
  assign take_cop = issue_live & dec_cop_unusable;
  assign take_ri = issue_live & dec_reserved;
  assign take_sys = issue_live & dec_system_call_instruction;
  assign take_bp = issue_live & dec_break;

  // Record for the instruction now in the exception stage;
  // used by every instruction check and by streaming bus errors
  always_comb begin
    issue_rec = sxu_restart(issue_i.pc, issue_i.prev_pc, issue_i.in_delay_slot,
                            issue_i.after_extend, issue_i.isa_compact,
                            mode_i.compact_en);
  end

  // Record for the instruction that owns the outstanding access;
  // it may have left the stage long before the error comes back
  always_comb begin
    access_rec = sxu_restart(access_i.pc, access_i.prev_pc, access_i.in_delay_slot,
                             access_i.after_extend, access_i.isa_compact,
                             mode_i.compact_en);
  end

  // Streaming lets later instructions run ahead of the refill, so the
  // restart point is the valid instruction now in the stage, else the access owner.
  // Handlers must not assume the restart names the faulting access then.
  always_comb begin
    stream_rec = issue_i.valid ? issue_rec : access_rec;
  end

  // Select the exception to take. A bus error belongs to an access that
  // was started earlier, so it beats anything the issuing instruction does.
  // Among instruction checks the order is coprocessor, reserved, call, break;
  // a coprocessor word also counts as reserved, as the major table leaves its opcodes undefined.
  // Fields that a cause does not use are written as zero, never left over
  // from the previous exception, so the handler never sees a stale mix.
  always_comb begin
    take_nxt = 1'b0;
    rec_nxt = '0;
    if (take_bus) begin
      // Record of the access owner, or of a valid stage instruction when streaming
      take_nxt = 1'b1;
      rec_nxt = mode_i.streaming ? stream_rec : access_rec;
      rec_nxt.code = access_i.is_fetch ? `SXU_CODE_IBE : `SXU_CODE_DBE;
      rec_nxt.coproc = '0;
    end else if (take_cop) begin
      // Only this cause reports a coprocessor number
      take_nxt = 1'b1;
      rec_nxt = issue_rec;
      rec_nxt.code = `SXU_CODE_CPU;
      rec_nxt.coproc = dec_cop_num;
    end else if (take_ri) begin
      // Undefined opcode, or a 64-bit one where it is not allowed
      take_nxt = 1'b1;
      rec_nxt = issue_rec;
      rec_nxt.code = `SXU_CODE_RI;
      rec_nxt.coproc = '0;
    end else if (take_sys) begin
      // The handler steps the restart past the call itself
      take_nxt = 1'b1;
      rec_nxt = issue_rec;
      rec_nxt.code = `SXU_CODE_SYS;
      rec_nxt.coproc = '0;
    end else if (take_bp) begin
      // Code bits of the breakpoint word stay free for the handler
      take_nxt = 1'b1;
      rec_nxt = issue_rec;
      rec_nxt.code = `SXU_CODE_BP;
      rec_nxt.coproc = '0;
    end
  end

  // Restart address advance after a call or break is left to the handler;
  // the hardware saves the trapping instruction itself, or the one before it when in a slot.

  // Flow: a taken exception spends one cycle flushing, then goes back idle.
  // That single cycle is what spaces two takes at least two cycles apart.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sxu_pkg::SXU_ST_IDLE: begin
        if (take_nxt) begin
          state_nxt = sxu_pkg::SXU_ST_FLUSH;
        end
      end
      sxu_pkg::SXU_ST_FLUSH: begin
        state_nxt = sxu_pkg::SXU_ST_IDLE;
      end
      default: begin
        state_nxt = sxu_pkg::SXU_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_r <= sxu_pkg::SXU_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Flush level mirrors the flush state so the pipeline kills its contents;
  // it is registered so the pipeline sees a clean level with no glitches
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= (state_nxt == sxu_pkg::SXU_ST_FLUSH);
    end
  end

  // One-cycle take pulse; no enable gates it, so nothing can mask a take
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      exc_take_o <= 1'b0;
    end else begin
      exc_take_o <= take_nxt;
    end
  end

  // Every exception handled here goes to the common vector; the special
  // refill vectors belong to other units and never come from this block.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      common_vector_o <= 1'b0;
    end else begin
      common_vector_o <= take_nxt;
    end
  end

  // Cause code holds until the next exception overwrites it,
  // so a handler may read it at any time after the take pulse;
  // a pulse alone would be lost if the handler is slow to start.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cause_code_field_o <= `SXU_CODE_NONE;
    end else if (take_nxt) begin
      cause_code_field_o <= rec_nxt.code;
    end
  end

  // Coprocessor number; zero for every cause but coprocessor unusable,
  // so software never reads a number left from an older exception
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      coproc_num_o <= '0;
    end else if (take_nxt) begin
      coproc_num_o <= rec_nxt.coproc;
    end
  end

  // Restart address; in compact mode bit 0 carries the instruction mode,
  // which the handler must keep when it returns
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      restart_address_o <= `SXU_ADDR_RST;
    end else if (take_nxt) begin
      restart_address_o <= rec_nxt.restart;
    end
  end

  // Delay-slot flag, written on every take: set in a slot, cleared
  // otherwise, so it always matches the restart address beside it
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      delay_slot_flag_o <= 1'b0;
    end else if (take_nxt) begin
      delay_slot_flag_o <= rec_nxt.delay_slot;
    end
  end

endmodule : sxu_top

`default_nettype wire

// >>> tb/sxu_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "sxu_cfg.svh"

module sxu_checker (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire sxu_pkg::sxu_issue_t issue_i,
  input wire sxu_pkg::sxu_access_t access_i,
  input wire sxu_pkg::sxu_mode_t mode_i,
  input wire logic bus_error_i,
  input wire logic exc_take_o,
  input wire logic common_vector_o,
  input wire logic flush_o,
  input wire logic [`SXU_CODE_W-1:0] cause_code_field_o,
  input wire logic [`SXU_COPN_W-1:0] coproc_num_o,
  input wire logic [`SXU_XLEN-1:0] restart_address_o,
  input wire logic delay_slot_flag_o
);
  localparam logic [63:0] MDEF = `SXU_MAJOR_DEF;
  logic plain;
  logic trap;
  // Plain-mode instruction with no bus error able to pre-empt it
  assign plain = issue_i.valid && !issue_i.isa_compact && !mode_i.compact_en
    && !access_i.active && !exc_take_o;
  assign trap = issue_i.word[31:26] == 6'h00 && issue_i.word[5:1] == 5'h06;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_vector_on_take: assert property (exc_take_o |-> common_vector_o && flush_o)
    else $error("vector or flush missing");
  chk_system_call_instruction_code: assert property (plain && trap && !issue_i.word[0] |=>
    exc_take_o && cause_code_field_o == `SXU_CODE_SYS) else $error("system_call_instruction not taken");
  chk_break_code: assert property (plain && trap && issue_i.word[0] |=>
    exc_take_o && cause_code_field_o == `SXU_CODE_BP) else $error("break not taken");
  chk_slot_record: assert property (plain && trap |=>
    delay_slot_flag_o == $past(issue_i.in_delay_slot) && restart_address_o ==
    ($past(issue_i.in_delay_slot) ? $past(issue_i.prev_pc) : $past(issue_i.pc)))
    else $error("restart or flag wrong");
  chk_cop_number: assert property (plain && issue_i.word[31:28] == 4'h4 && !mode_i.kernel
    && !mode_i.cop_usable[issue_i.word[27:26]] |=> cause_code_field_o == `SXU_CODE_CPU
    && coproc_num_o == $past(issue_i.word[27:26])) else $error("coprocessor record wrong");
  chk_major_reserved: assert property (plain && !MDEF[issue_i.word[31:26]]
    && issue_i.word[31:28] != 4'h4 |=> cause_code_field_o == `SXU_CODE_RI)
    else $error("reserved major missed");
  chk_bus_err_code: assert property (bus_error_i ##2 (access_i.active && !exc_take_o) |=>
    exc_take_o && cause_code_field_o == ($past(access_i.is_fetch) ? `SXU_CODE_IBE : `SXU_CODE_DBE))
    else $error("bus error code wrong");
  chk_bus_err_drop: assert property (bus_error_i ##2 (!access_i.active && !issue_i.valid)
    |=> !exc_take_o) else $error("bus error taken without access");
  // Records must only move on a take, or the handler reads a stale mix
  chk_record_holds: assert property (!exc_take_o |-> $stable(cause_code_field_o)
    && $stable(restart_address_o)) else $error("record moved without take");
endmodule : sxu_checker

bind sxu_top sxu_checker u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .issue_i(issue_i), .access_i(access_i), .mode_i(mode_i), .bus_error_i(bus_error_i),
  .exc_take_o(exc_take_o), .common_vector_o(common_vector_o), .flush_o(flush_o),
  .cause_code_field_o(cause_code_field_o), .coproc_num_o(coproc_num_o),
  .restart_address_o(restart_address_o), .delay_slot_flag_o(delay_slot_flag_o));

`default_nettype wire

// >>> tb/sxu_board_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "sxu_cfg.svh"

module sxu_board_model (
  input wire logic core_clk_i,
  input wire logic fire_i,
  input wire logic open_i,
  input wire logic fetch_i,
  input wire logic [`SXU_XLEN-1:0] pc_i,
  output logic bus_error_o,
  output var sxu_pkg::sxu_access_t access_o
);
  logic [2:0] left_r = 3'h0;
  logic [`SXU_XLEN-1:0] pc_r = 32'h0;
  logic fetch_r = 1'b0;
  // One access window per request; a one-cycle strobe avoids a second take
  always @(posedge core_clk_i) begin
    bus_error_o <= fire_i;
    if (fire_i) begin
      left_r <= open_i ? 3'h6 : 3'h0;
      pc_r <= pc_i;
      fetch_r <= fetch_i;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end
  end
  // Released lines show inverted data so stale values cannot pass
  always_comb begin
    access_o = '0;
    access_o.active = left_r != 3'h0;
    access_o.is_fetch = access_o.active ? fetch_r : !fetch_r;
    access_o.pc = access_o.active ? pc_r : ~pc_r;
    access_o.prev_pc = ~pc_r;
  end
endmodule : sxu_board_model

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sxu_cfg.svh"

module testbench;
  localparam logic [31:0] pc_a = 32'h0000_1040;
  localparam logic [31:0] pc_b = 32'h0000_103c;
  logic core_clk_i, rst_b_i, fire, open_acc, fetch, bus_err, take, vec, flush, slot;
  sxu_pkg::sxu_issue_t issue;
  sxu_pkg::sxu_mode_t mode;
  sxu_pkg::sxu_access_t access;
  logic [4:0] code;
  logic [1:0] copn;
  logic [31:0] restart;
  int err_total, checks;

  sxu_top dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .issue_i(issue), .access_i(access),
    .mode_i(mode), .bus_error_i(bus_err), .exc_take_o(take), .common_vector_o(vec),
    .flush_o(flush), .cause_code_field_o(code), .coproc_num_o(copn),
    .restart_address_o(restart), .delay_slot_flag_o(slot));
  sxu_board_model board (.core_clk_i(core_clk_i), .fire_i(fire), .open_i(open_acc),
    .fetch_i(fetch), .pc_i(pc_a), .bus_error_o(bus_err), .access_o(access));

  task automatic cmp_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_vec

  task automatic end_sim;
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Instruction held for two edges; the second copy lands in the flush cycle
  task automatic run_insn(input logic [31:0] word, input logic cpt, input logic [1:0] where,
      input logic take_exp, input logic [4:0] code_exp);
    logic ds;
    logic [31:0] addr;
    ds = where[0] | (where[1] & mode.compact_en);
    addr = ds ? pc_b : pc_a;
    if (mode.compact_en) addr[0] = cpt;
    issue = '{1'b1, word, pc_a, pc_b, where[0], where[1], cpt};
    @(posedge core_clk_i);
    #1;
    cmp_vec("take", {31'h0, take_exp}, {31'h0, take});
    if (take_exp) begin
      cmp_vec("vector", 32'h1, {31'h0, vec});
      cmp_vec("flush", 32'h1, {31'h0, flush});
      cmp_vec("cause", {27'h0, code_exp}, {27'h0, code});
      cmp_vec("restart", addr, restart);
      cmp_vec("slot flag", {31'h0, ds}, {31'h0, slot});
    end
    @(posedge core_clk_i);
    #1;
    issue.valid = 1'b0;
    cmp_vec("flush take", 32'h0, {31'h0, take});
    cmp_vec("flush end", 32'h0, {31'h0, flush});
    @(posedge core_clk_i);
    #1;
  endtask : run_insn

  task automatic sc_system_call_instruction;
    run_insn(32'h0000_000c, 1'b0, 2'b00, 1'b1, `SXU_CODE_SYS);
    run_insn(32'h0000_000c, 1'b0, 2'b01, 1'b1, `SXU_CODE_SYS);
    run_insn(32'h0000_000c, 1'b0, 2'b10, 1'b1, `SXU_CODE_SYS);
  endtask : sc_system_call_instruction

  task automatic sc_break;
    run_insn(32'h03ff_ffcd, 1'b0, 2'b01, 1'b1, `SXU_CODE_BP);
    mode.compact_en = 1'b1;
    run_insn(32'h0000_e805, 1'b1, 2'b00, 1'b1, `SXU_CODE_BP);
    run_insn(32'h0000_e805, 1'b1, 2'b10, 1'b1, `SXU_CODE_BP);
    mode.compact_en = 1'b0;
  endtask : sc_break

  task automatic sc_cop;
    for (int n = 0; n < 4; n++) begin
      mode.cop_usable = ~(4'h1 << n);
      run_insn({4'h4, 2'(n), 26'h0}, 1'b0, 2'b00, 1'b1, `SXU_CODE_CPU);
      cmp_vec("coproc", 32'(n), {30'h0, copn});
    end
    mode.cop_usable = 4'h0;
  endtask : sc_cop

  task automatic sc_reserved;
    logic [31:0] w [6] = '{32'h7000_0000, 32'h0000_0001, 32'h0404_0000, 32'h6000_0000,
      32'h0000_e801, 32'h0000_6700};
    for (int i = 0; i < 6; i++) begin
      mode.compact_en = i > 3;
      run_insn(w[i], i > 3, 2'b00, 1'b1, `SXU_CODE_RI);
    end
    mode.compact_en = 1'b0;
    mode.kernel = 1'b1;
    run_insn(32'h6000_0000, 1'b0, 2'b00, 1'b0, 5'h00);
    mode.kernel = 1'b0;
  endtask : sc_reserved

  // Error strobe from the board, then a bounded wait for the take
  task automatic bus_case(input logic opened, input logic is_f, input logic take_exp,
      input logic [4:0] code_exp, input logic [31:0] addr_exp);
    int n;
    open_acc = opened;
    fetch = is_f;
    fire = 1'b1;
    @(posedge core_clk_i);
    #1;
    fire = 1'b0;
    n = 0;
    while (take !== 1'b1 && n < 8) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (take_exp && n == 8) begin
      err_total++;
      end_sim();
    end
    cmp_vec("bus take", {31'h0, take_exp}, {31'h0, take});
    if (take_exp) begin
      cmp_vec("bus cause", {27'h0, code_exp}, {27'h0, code});
      cmp_vec("bus restart", addr_exp, restart);
    end
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask : bus_case

  task automatic sc_bus;
    bus_case(1'b1, 1'b1, 1'b1, `SXU_CODE_IBE, pc_a);
    bus_case(1'b1, 1'b0, 1'b1, `SXU_CODE_DBE, pc_a);
    bus_case(1'b0, 1'b1, 1'b0, 5'h00, pc_a);
  endtask : sc_bus

  // Streaming: a harmless instruction sits in the stage, its address is saved
  task automatic sc_stream;
    mode.streaming = 1'b1;
    issue = '{1'b1, 32'h0, pc_b, pc_a, 1'b0, 1'b0, 1'b0};
    bus_case(1'b1, 1'b0, 1'b1, `SXU_CODE_DBE, pc_b);
    issue = '0;
    mode.streaming = 1'b0;
  endtask : sc_stream

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  initial begin
    err_total = 0;
    checks = 0;
    rst_b_i = 1'b0;
    fire = 1'b0;
    open_acc = 1'b0;
    fetch = 1'b0;
    issue = '0;
    mode = '0;
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    cmp_vec("reset cause", {27'h0, `SXU_CODE_NONE}, {27'h0, code});
    cmp_vec("reset restart", `SXU_ADDR_RST, restart);
    sc_system_call_instruction();
    sc_break();
    sc_cop();
    sc_reserved();
    sc_bus();
    sc_stream();
    end_sim();
  end
endmodule : testbench

`default_nettype wire
